// *** logic/bin_ctrl_pkg.sv ***
// Package: constants and types for the binning and reset control inputs
package bin_ctrl_pkg;

    // Row binning select codes, high bit then low bit
    localparam logic [1:0] ROW_SEL_1X = 2'h0;
    localparam logic [1:0] ROW_SEL_2X = 2'h1;
    localparam logic [1:0] ROW_SEL_4X = 2'h2;

    // Binning factors expressed as group sizes
    localparam logic [2:0] BIN_FACTOR_1 = 3'h1;
    localparam logic [2:0] BIN_FACTOR_2 = 3'h2;
    localparam logic [2:0] BIN_FACTOR_4 = 3'h4;

    // Group counter width and its reset value
    localparam int          GRP_W       = 2;
    localparam logic [1:0]  GRP_RST     = 2'h0;

    // Synchroniser reset, order {mrst_n, hi, lo, col, arst_n, xfer}
    localparam logic [5:0]  SYNC_RST    = 6'h22;

    // Reset values of the registered outputs
    localparam logic        RST_LOW     = 1'h0;
    localparam logic        RST_HIGH    = 1'h1;

    typedef enum logic [1:0] {
        MODE_1X,
        MODE_2X,
        MODE_4X
    } row_mode_t;

    typedef enum {
        ST_IDLE,
        ST_ARRAY_RESET,
        ST_RUN
    } ctrl_state_t;

    // Binning configuration as presented to the readout path
    typedef struct packed {
        logic [2:0] row_factor;
        logic [2:0] col_factor;
    } bin_cfg_t;

    // Per-sample strobes from the readout sequencer
    typedef struct packed {
        logic row_done;
        logic pix_done;
    } readout_evt_t;

    // Output strobes that mark a finished binned row or pixel group
    typedef struct packed {
        logic row_emit;
        logic pix_emit;
    } bin_emit_t;

endpackage

// *** logic/bin_reset_ctrl.sv ***
// Binning select decode, group emission and reset control of the sensor
module bin_reset_ctrl
    import bin_ctrl_pkg::*;
(
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       clk_en_i,
    input  wire logic                       master_reset_n_i,
    input  wire logic                       slave_mode_i,
    input  wire logic                       row_bin_sel_hi_i,
    input  wire logic                       row_bin_sel_lo_i,
    input  wire logic                       col_bin_sel_lo_i,
    input  wire logic                       pixel_array_reset_n_i,
    input  wire logic                       charge_transfer_i,
    input  wire bin_ctrl_pkg::readout_evt_t evt_i,
    output logic                            global_pixel_reset_o,
    output logic                            sm_default_o,
    output bin_ctrl_pkg::bin_cfg_t          cfg_o,
    output bin_ctrl_pkg::bin_emit_t         emit_o
);
    import bin_ctrl_pkg::*;

    localparam int NPIN = 6;

    // Pin synchronisers; stage one feeds stage two only
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_ff;
    logic [NPIN-1:0] sync2_ff;

    assign pin_raw = {master_reset_n_i, row_bin_sel_hi_i, row_bin_sel_lo_i,
                      col_bin_sel_lo_i, pixel_array_reset_n_i,
                      charge_transfer_i};

    // Selects and transfer reset low so the first latch after reset is 1x
    // Clock enable low freezes every flop, synchronisers included
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    sync1_ff[gi] <= SYNC_RST[gi];
                    sync2_ff[gi] <= SYNC_RST[gi];
                end else if (clk_en_i) begin
                    sync1_ff[gi] <= pin_raw[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end
        end
    endgenerate

    logic mrst_n_s;
    logic sel_hi_s;
    logic sel_lo_s;
    logic col_s;
    logic arst_n_s;
    logic xfer_s;

    assign {mrst_n_s, sel_hi_s, sel_lo_s, col_s, arst_n_s, xfer_s} = sync2_ff;

    // Row select decode; the unused code 11 falls back to 1x
    row_mode_t nxt_mode;

    always_comb begin
        case ({sel_hi_s, sel_lo_s})
            ROW_SEL_1X: nxt_mode = MODE_1X;
            ROW_SEL_2X: nxt_mode = MODE_2X;
            ROW_SEL_4X: nxt_mode = MODE_4X;
            default:    nxt_mode = MODE_1X;
        endcase
    end

    // Control state machine
    ctrl_state_t state_ff;
    ctrl_state_t nxt_state;
    logic        arr_rst_req;

    // Array reset needs slave mode and the transfer pin; master reset wins
    assign arr_rst_req = slave_mode_i && !arst_n_s && xfer_s;

    always_comb begin
        case (state_ff)
            ST_IDLE:        nxt_state = arr_rst_req ? ST_ARRAY_RESET : ST_RUN;
            ST_ARRAY_RESET: nxt_state = arr_rst_req ? ST_ARRAY_RESET : ST_RUN;
            ST_RUN:         nxt_state = arr_rst_req ? ST_ARRAY_RESET : ST_RUN;
            default:        nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_IDLE;
        end else if (clk_en_i) begin
            if (!mrst_n_s) begin
                state_ff <= ST_IDLE;
            end else begin
                state_ff <= nxt_state;
            end
        end
    end

    // Mode is latched only outside run so a mode change cannot split a group
    row_mode_t mode_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_ff <= MODE_1X;
        end else if (clk_en_i) begin
            if (!mrst_n_s) begin
                mode_ff <= MODE_1X;
            end else if (state_ff != ST_RUN) begin
                mode_ff <= nxt_mode;
            end
        end
    end

    logic col4_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            col4_ff <= RST_LOW;
        end else if (clk_en_i) begin
            if (!mrst_n_s) begin
                col4_ff <= RST_LOW;
            end else if (state_ff != ST_RUN) begin
                col4_ff <= col_s;
            end
        end
    end

    // Group counters for rows and pixels
    // Counters only run in run state; any other state clears them
    logic [GRP_W-1:0] row_cnt_ff;
    logic [GRP_W-1:0] pix_cnt_ff;
    logic [GRP_W-1:0] row_last;
    logic [GRP_W-1:0] pix_last;
    logic             run;

    assign run = (state_ff == ST_RUN);

    always_comb begin
        case (mode_ff)
            MODE_1X: row_last = GRP_W'(BIN_FACTOR_1 - 3'h1);
            MODE_2X: row_last = GRP_W'(BIN_FACTOR_2 - 3'h1);
            MODE_4X: row_last = GRP_W'(BIN_FACTOR_4 - 3'h1);
            default: row_last = GRP_RST;
        endcase
        pix_last = col4_ff ? GRP_W'(BIN_FACTOR_4 - 3'h1)
                           : GRP_W'(BIN_FACTOR_1 - 3'h1);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            row_cnt_ff  <= GRP_RST;
            emit_o.row_emit <= RST_LOW;
        end else if (clk_en_i) begin
            emit_o.row_emit <= RST_LOW;
            if (!mrst_n_s || !run) begin
                row_cnt_ff <= GRP_RST;
            end else if (evt_i.row_done) begin
                if (row_cnt_ff == row_last) begin
                    row_cnt_ff      <= GRP_RST;
                    emit_o.row_emit <= RST_HIGH;
                end else begin
                    row_cnt_ff <= row_cnt_ff + 2'h1;
                end
            end
        end
    end

    // Row done clears the pixel group so a new line starts cleanly
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pix_cnt_ff  <= GRP_RST;
            emit_o.pix_emit <= RST_LOW;
        end else if (clk_en_i) begin
            emit_o.pix_emit <= RST_LOW;
            if (!mrst_n_s || !run || evt_i.row_done) begin
                pix_cnt_ff <= GRP_RST;
            end else if (evt_i.pix_done) begin
                if (pix_cnt_ff == pix_last) begin
                    pix_cnt_ff      <= GRP_RST;
                    emit_o.pix_emit <= RST_HIGH;
                end else begin
                    pix_cnt_ff <= pix_cnt_ff + 2'h1;
                end
            end
        end
    end

    // Registered outputs
    // Every output is a flop so the readout path sees no decode glitches
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            global_pixel_reset_o <= RST_LOW;
            sm_default_o         <= RST_HIGH;
            cfg_o.row_factor     <= BIN_FACTOR_1;
            cfg_o.col_factor     <= BIN_FACTOR_1;
        end else if (clk_en_i) begin
            global_pixel_reset_o <= mrst_n_s && arr_rst_req;
            sm_default_o         <= !mrst_n_s;
            case (mode_ff)
                MODE_2X: cfg_o.row_factor <= BIN_FACTOR_2;
                MODE_4X: cfg_o.row_factor <= BIN_FACTOR_4;
                default: cfg_o.row_factor <= BIN_FACTOR_1;
            endcase
            cfg_o.col_factor <= col4_ff ? BIN_FACTOR_4 : BIN_FACTOR_1;
        end
    end

endmodule

// *** verification/bin_reset_ctrl_chk.sv ***
// Checker: concurrent assertions on the binning and reset control ports
module bin_reset_ctrl_chk
    import bin_ctrl_pkg::*;
(
    input wire logic         clk_sys_i,
    input wire logic         rst_n_i,
    input wire logic         clk_en_i,
    input wire logic         master_reset_n_i,
    input wire logic         slave_mode_i,
    input wire logic         row_bin_sel_hi_i,
    input wire logic         row_bin_sel_lo_i,
    input wire logic         col_bin_sel_lo_i,
    input wire logic         pixel_array_reset_n_i,
    input wire logic         charge_transfer_i,
    input wire readout_evt_t evt_i,
    input wire logic         global_pixel_reset_o,
    input wire logic         sm_default_o,
    input wire bin_cfg_t     cfg_o,
    input wire bin_emit_t    emit_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Three samples cover the two synchroniser stages plus the output flop
    sequence s_mrst_held;
        (!master_reset_n_i) [*3];
    endsequence
    a_row_cause: assert property (emit_o.row_emit |-> $past(evt_i.row_done))
        else $error("row emit without a row done");
    a_one_emit: assert property (cfg_o.row_factor == BIN_FACTOR_1
        && evt_i.row_done && !sm_default_o && !global_pixel_reset_o
        && clk_en_i && !$past(sm_default_o) && !$past(global_pixel_reset_o)
        && $past(master_reset_n_i, 2)
        |=> emit_o.row_emit) else $error("row emit missing in 1x");
    a_two_gap: assert property (cfg_o.row_factor == BIN_FACTOR_2
        && emit_o.row_emit |=> !emit_o.row_emit) else $error("2x gap");
    a_four_gap: assert property (cfg_o.row_factor == BIN_FACTOR_4
        && emit_o.row_emit |=> !emit_o.row_emit [*3]) else $error("4x gap");
    a_col_gap: assert property (cfg_o.col_factor == BIN_FACTOR_4
        && emit_o.pix_emit |=> !emit_o.pix_emit [*3]) else $error("col gap");
    a_arr_rise: assert property ($rose(global_pixel_reset_o) |->
        !$past(pixel_array_reset_n_i, 3) && $past(charge_transfer_i, 3))
        else $error("array reset without its cause");
    a_slave_gate: assert property ((!slave_mode_i) [*4]
        |-> !global_pixel_reset_o) else $error("array reset outside slave");
    a_mrst_default: assert property (s_mrst_held |=> sm_default_o)
        else $error("master reset not seen");
    a_mrst_cfg: assert property ((!master_reset_n_i) [*5] |=>
        cfg_o.row_factor == BIN_FACTOR_1 && !global_pixel_reset_o)
        else $error("master reset left a mode");
endmodule
bind bin_reset_ctrl bin_reset_ctrl_chk chk_i (.*);

// *** verification/ctrl_model.sv ***
// Partner model: external controller that keeps the control pins driven
module ctrl_model (
    input  wire logic       clk_sys_i,
    input  wire logic [4:0] rq_i,
    output logic      [4:0] pins_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pins never float: a value is driven from time zero on
    logic [4:0] pins_ff = 5'h03;
    // Order hi, lo, col, array reset, transfer; transfer set with reset
    always @(posedge clk_sys_i) begin
        pins_ff <= rq_i;
    end
    assign pins_o = pins_ff;
endmodule

// *** verification/tb_binning_and_reset_control_inputs.sv ***
// Testbench: table of binning modes, then reset and array reset cases
module tb_binning_and_reset_control_inputs;
    timeunit 1ns;
    timeprecision 1ns;
    import bin_ctrl_pkg::*;
    typedef struct packed {
        logic [2:0] sel;
        logic [2:0] rf;
        logic [2:0] cf;
    } case_t;
    case_t        tbl [5] = '{'{3'h0, 3'h1, 3'h1}, '{3'h2, 3'h2, 3'h1},
                              '{3'h4, 3'h4, 3'h1}, '{3'h1, 3'h1, 3'h4},
                              '{3'h6, 3'h1, 3'h1}};
    logic         clk_sys_i = 1'h0;
    logic         rst_n_i = 1'h0;
    logic         mrst_n = 1'h1;
    logic         en = 1'h1;
    logic         slave = 1'h1;
    logic [4:0]   rq = 5'h03;
    logic [4:0]   pins;
    readout_evt_t evt = '0;
    logic         gpr;
    logic         smd;
    bin_cfg_t     cfg;
    bin_emit_t    emit;
    int           error_cnt = 0;
    int           num_checks = 0;
    int           cyc = 0;
    int           rcnt = 0;
    int           pcnt = 0;
    int           r0;
    int           p0;
    ctrl_model ctl (.clk_sys_i(clk_sys_i), .rq_i(rq), .pins_o(pins));
    bin_reset_ctrl uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .clk_en_i(en), .master_reset_n_i(mrst_n), .slave_mode_i(slave),
        .row_bin_sel_hi_i(pins[4]), .row_bin_sel_lo_i(pins[3]),
        .col_bin_sel_lo_i(pins[2]), .pixel_array_reset_n_i(pins[1]),
        .charge_transfer_i(pins[0]), .evt_i(evt),
        .global_pixel_reset_o(gpr), .sm_default_o(smd), .cfg_o(cfg),
        .emit_o(emit));
    initial forever #10 clk_sys_i = ~clk_sys_i;
    // Emission pulses last one cycle, so they are counted at every edge
    always @(posedge clk_sys_i) begin
        cyc++;
        if (emit.row_emit === 1'h1) rcnt++;
        if (emit.pix_emit === 1'h1) pcnt++;
        if (cyc == 1000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic pulse(input readout_evt_t e);
        repeat (4) begin
            @(posedge clk_sys_i) evt <= e;
        end
        @(posedge clk_sys_i) evt <= '0;
    endtask
    // Selects are latched only outside the run state, so relatch them
    task automatic mrst();
        @(posedge clk_sys_i) mrst_n <= 1'h0;
        wait_n(6);
        mrst_n <= 1'h1;
        wait_n(10);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        wait_n(6);
        chk({2'h0, gpr}, 3'h0);
        chk({2'h0, smd}, 3'h1);
        chk(cfg.row_factor, BIN_FACTOR_1);
        rst_n_i <= 1'h1;
        wait_n(4);
        chk(cfg.col_factor, BIN_FACTOR_1);
        foreach (tbl[i]) begin
            @(posedge clk_sys_i) rq <= {tbl[i].sel, 2'h3};
            mrst();
            chk(cfg.row_factor, tbl[i].rf);
            chk(cfg.col_factor, tbl[i].cf);
            r0 = rcnt;
            p0 = pcnt;
            pulse(2'h1);
            pulse(2'h2);
            wait_n(3);
            chk(3'(pcnt - p0), 3'(4 / tbl[i].cf));
            chk(3'(rcnt - r0), 3'(4 / tbl[i].rf));
        end
        @(posedge clk_sys_i) rq <= 5'h00;
        wait_n(8);
        chk({2'h0, gpr}, 3'h0);
        rq <= 5'h01;
        wait_n(6);
        chk({2'h0, gpr}, 3'h1);
        slave <= 1'h0;
        wait_n(6);
        chk({2'h0, gpr}, 3'h0);
        slave <= 1'h1;
        rq <= 5'h07;
        wait_n(6);
        chk(cfg.col_factor, BIN_FACTOR_4);
        @(posedge clk_sys_i) mrst_n <= 1'h0;
        wait_n(6);
        chk({2'h0, smd}, 3'h1);
        chk(cfg.col_factor, BIN_FACTOR_1);
        mrst_n <= 1'h1;
        wait_n(10);
        chk({2'h0, smd}, 3'h0);
        r0 = rcnt;
        en <= 1'h0;
        pulse(2'h2);
        wait_n(2);
        chk(3'(rcnt - r0), 3'h0);
        en <= 1'h1;
        pulse(2'h2);
        wait_n(3);
        chk(3'(rcnt - r0), 3'h4);
        tally_and_finish();
    end
endmodule
